// File: rdv_pkg.sv
// Package with the shared constants and types of the discrepancy voter.
package rdv_pkg;

   // ==========================================================
   // Widths and defaults.
   // ==========================================================
   localparam int RDV_WIDTH = 8;
   localparam int RDV_TMR_W = 16;
   localparam logic [15:0] RDV_ERR_UNLOCALIZED = 16'h1F18; // Code 7960.

   // ==========================================================
   // Discrepancy response choices applied after expiry.
   // ==========================================================
   localparam logic [1:0] RDV_RESP_HOLD = 2'h0;
   localparam logic [1:0] RDV_RESP_CH_A = 2'h1;
   localparam logic [1:0] RDV_RESP_CH_B = 2'h2;
   localparam logic [1:0] RDV_RESP_ZERO = 2'h3;

   // Per-bit voter states.
   typedef enum logic [1:0] {
      RDV_AGREE,
      RDV_TIMING,
      RDV_EXPIRED,
      RDV_LOCALIZED
   } rdv_state_e;

   // Error event carried to the diagnostic side.
   typedef struct packed {
      logic valid;
      logic [15:0] code;
      logic [7:0] bit_idx;
   } rdv_event_s;

endpackage

// File: rdv_bit.sv
// Voter for one redundant input bit pair with its own discrepancy timer.
`timescale 1ns/1ps
module rdv_bit
   import rdv_pkg::*;
#(
   parameter int TMR_W = RDV_TMR_W
)
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Update tick and channel bits.
   input wire logic tick_i,
   input wire logic ch_a_i,
   input wire logic ch_b_i,
   // Configuration.
   input wire logic [TMR_W-1:0] disc_ticks_i,
   input wire logic [1:0] resp_i,
   // Passivation by the diagnostic interrupt handler.
   input wire logic diag_pass_a_i,
   input wire logic diag_pass_b_i,
   // Results.
   output logic value_o,
   output logic marked_o,
   output logic expire_o,
   output logic pass_a_o,
   output logic pass_b_o
);

   // ==========================================================
   // State and held values.
   // ==========================================================
   rdv_state_e state_r;
   logic [TMR_W-1:0] tmr_r;
   logic agreed_r;
   logic prev_a_r;
   logic prev_b_r;
   logic val_r;
   logic exp_r;
   logic pass_a_r;
   logic pass_b_r;
   logic a_chg;
   logic b_chg;

   // Transition detection against the previous tick's samples.
   assign a_chg = ch_a_i != prev_a_r;
   assign b_chg = ch_b_i != prev_b_r;

   // Sample history moves only on update ticks.
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         prev_a_r <= 1'b0;
         prev_b_r <= 1'b0;
      end
      else if (tick_i)
      begin
         prev_a_r <= ch_a_i;
         prev_b_r <= ch_b_i;
      end
   end

   // Voter state, timer and image value, counted in whole ticks.
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         state_r <= RDV_AGREE;
         tmr_r <= '0;
         agreed_r <= 1'b0;
         val_r <= 1'b0;
         exp_r <= 1'b0;
      end
      else
      begin
         exp_r <= 1'b0;
         if (tick_i)
         begin
            case (state_r)
               RDV_AGREE:
               begin
                  if (ch_a_i == ch_b_i)
                  begin
                     agreed_r <= ch_a_i;
                     val_r <= ch_a_i;
                  end
                  else
                  begin
                     // A stuck-at-1 or stuck-at-0 side shows here.
                     state_r <= RDV_TIMING;
                     tmr_r <= '0;
                     val_r <= agreed_r;
                  end
               end
               RDV_TIMING:
               begin
                  if (ch_a_i == ch_b_i)
                  begin
                     state_r <= RDV_AGREE;
                     tmr_r <= '0;
                     agreed_r <= ch_a_i;
                     val_r <= ch_a_i;
                  end
                  else if (tmr_r + TMR_W'(1) >= disc_ticks_i)
                  begin
                     // Expiry reports only; no passivation here.
                     state_r <= RDV_EXPIRED;
                     exp_r <= 1'b1;
                  end
                  else
                  begin
                     tmr_r <= tmr_r + TMR_W'(1);
                     val_r <= agreed_r;
                  end
               end
               RDV_EXPIRED:
               begin
                  if (a_chg != b_chg)
                  begin
                     state_r <= RDV_LOCALIZED;
                     val_r <= a_chg ? ch_a_i : ch_b_i;
                  end
                  else
                  begin
                     case (resp_i)
                        RDV_RESP_CH_A: val_r <= ch_a_i;
                        RDV_RESP_CH_B: val_r <= ch_b_i;
                        RDV_RESP_ZERO: val_r <= 1'b0;
                        default: val_r <= agreed_r;
                     endcase
                  end
               end
               default:
               begin
                  // The surviving channel feeds the image from now on.
                  val_r <= pass_a_r ? ch_b_i : ch_a_i;
               end
            endcase
         end
      end
   end

   // Passivation flags are sticky until reset.
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         pass_a_r <= 1'b0;
         pass_b_r <= 1'b0;
      end
      else
      begin
         if (diag_pass_a_i)
            pass_a_r <= 1'b1;
         if (diag_pass_b_i)
            pass_b_r <= 1'b1;
         if (tick_i && state_r == RDV_EXPIRED && a_chg != b_chg)
         begin
            if (a_chg)
               pass_b_r <= 1'b1;
            else
               pass_a_r <= 1'b1;
         end
      end
   end

   // Outputs.
   assign value_o = val_r;
   assign marked_o = state_r != RDV_AGREE;
   assign expire_o = exp_r;
   assign pass_a_o = pass_a_r;
   assign pass_b_o = pass_b_r;

endmodule

// File: rdv_voter.sv
// Top of the redundant digital input discrepancy voter.
`timescale 1ns/1ps
module rdv_voter
   import rdv_pkg::*;
#(
   parameter int WIDTH = RDV_WIDTH,
   parameter int TMR_W = RDV_TMR_W
)
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Process image update tick.
   input wire logic tick_i,
   // Redundant channel read-back.
   input wire logic [WIDTH-1:0] ch_a_i,
   input wire logic [WIDTH-1:0] ch_b_i,
   // Configuration: discrepancy time in ticks, response choice.
   input wire logic [TMR_W-1:0] disc_ticks_i,
   input wire logic [1:0] resp_i,
   // Diagnostic interrupt handler passivation requests.
   input wire logic diag_pass_a_i,
   input wire logic diag_pass_b_i,
   // Image and status.
   output logic [WIDTH-1:0] image_o,
   output logic [WIDTH-1:0] marked_o,
   output logic [WIDTH-1:0] pass_a_o,
   output logic [WIDTH-1:0] pass_b_o,
   output logic [WIDTH-1:0] static_err_o,
   output rdv_event_s event_o
);

   // ==========================================================
   // Elaboration checks.
   // ==========================================================
   // The event carries an eight-bit index, which caps the width at 256.
   if (WIDTH < 1 || WIDTH > 256)
   begin : g_bad_width
      $error("WIDTH must be 1 to 256");
   end
   if (TMR_W < 1)
   begin : g_bad_tmr
      $error("TMR_W must be positive");
   end

   logic [WIDTH-1:0] exp_w;
   rdv_event_s ev_r;

   // ==========================================================
   // One voter per bit; timers are independent.
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         rdv_bit #(.TMR_W(TMR_W)) u_bit (
            .ref_clk_i(ref_clk_i),
            .nrst_i(nrst_i),
            .tick_i(tick_i),
            .ch_a_i(ch_a_i[g]),
            .ch_b_i(ch_b_i[g]),
            .disc_ticks_i(disc_ticks_i),
            .resp_i(resp_i),
            .diag_pass_a_i(diag_pass_a_i),
            .diag_pass_b_i(diag_pass_b_i),
            .value_o(image_o[g]),
            .marked_o(marked_o[g]),
            .expire_o(exp_w[g]),
            .pass_a_o(pass_a_o[g]),
            .pass_b_o(pass_b_o[g])
         );
      end
   endgenerate

   // Expiry never touches the static error image.
   assign static_err_o = '0;

   // Error event: one pulse per tick with an expiry, lowest bit reported when several
   // expire on the same tick; the others are still flagged in marked_o.
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         ev_r <= '0;
      else
      begin
         ev_r <= '0;
         for (int i = WIDTH - 1; i >= 0; i--)
         begin
            if (exp_w[i])
            begin
               ev_r.valid <= 1'b1;
               ev_r.code <= RDV_ERR_UNLOCALIZED;
               ev_r.bit_idx <= 8'(i);
            end
         end
      end
   end

   assign event_o = ev_r;

endmodule

// File: rdv_voter_props.sv
// Port-level checker for the discrepancy voter.
`timescale 1ns/1ps
module rdv_voter_props
   import rdv_pkg::*;
#(
   parameter int WIDTH = RDV_WIDTH,
   parameter int TMR_W = RDV_TMR_W
)
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Inputs of the voter.
   input wire logic tick_i,
   input wire logic [WIDTH-1:0] ch_a_i,
   input wire logic [WIDTH-1:0] ch_b_i,
   input wire logic [TMR_W-1:0] disc_ticks_i,
   input wire logic [1:0] resp_i,
   input wire logic diag_pass_a_i,
   input wire logic diag_pass_b_i,
   // Outputs of the voter.
   input wire logic [WIDTH-1:0] image_o,
   input wire logic [WIDTH-1:0] marked_o,
   input wire logic [WIDTH-1:0] pass_a_o,
   input wire logic [WIDTH-1:0] pass_b_o,
   input wire logic [WIDTH-1:0] static_err_o,
   input wire rdv_event_s event_o
);
   // ======
   // Checks.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // Voting may land one or two edges after the tick.
   static_zero_a: assert property (static_err_o == '0)
      else $error("static error image set");
   event_code_a: assert property (event_o.valid |->
      event_o.code == RDV_ERR_UNLOCALIZED) else $error("bad event code");
   // Back-to-back ticks may expire bits on neighbouring ticks.
   event_pulse_a: assert property (event_o.valid |=>
      !event_o.valid || $past(tick_i, 2))
      else $error("event longer than one cycle");
   // The edge after a reset compares against pre-reset samples, so skip it.
   mark_tick_a: assert property ($past(nrst_i) &&
      $changed(marked_o) |-> $past(tick_i) || $past(tick_i, 2))
      else $error("mark off tick");
   pass_sticky_a: assert property ($past(nrst_i) |->
      (($past(pass_a_o) & ~pass_a_o) | ($past(pass_b_o) & ~pass_b_o)) == '0)
      else $error("pass dropped");
   diag_left_a: assert property (diag_pass_a_i |-> ##[1:2] &pass_a_o)
      else $error("side a not passivated");
   diag_right_a: assert property (diag_pass_b_i |-> ##[1:2] &pass_b_o)
      else $error("side b not passivated");
   agree_image_a: assert property (tick_i && ch_a_i == ch_b_i &&
      marked_o == '0 && (pass_a_o | pass_b_o) == '0 |->
      ##1 image_o == $past(ch_a_i) or ##2 image_o == $past(ch_a_i, 2))
      else $error("agreed value not imaged");
   mismatch_mark_a: assert property (tick_i && ch_a_i != ch_b_i |->
      ##1 (marked_o & $past(ch_a_i ^ ch_b_i)) == $past(ch_a_i ^ ch_b_i) or
      ##2 (marked_o & $past(ch_a_i ^ ch_b_i, 2)) == $past(ch_a_i ^ ch_b_i, 2))
      else $error("mismatch not marked");
   // Main scenarios.
   expiry_c: cover property (event_o.valid);
   pass_a_c: cover property (|pass_a_o);
   pass_b_c: cover property (|pass_b_o);
endmodule
bind rdv_voter rdv_voter_props #(.WIDTH(WIDTH), .TMR_W(TMR_W)) u_props (
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tick_i(tick_i),
   .ch_a_i(ch_a_i), .ch_b_i(ch_b_i), .disc_ticks_i(disc_ticks_i),
   .resp_i(resp_i), .diag_pass_a_i(diag_pass_a_i),
   .diag_pass_b_i(diag_pass_b_i), .image_o(image_o), .marked_o(marked_o),
   .pass_a_o(pass_a_o), .pass_b_o(pass_b_o),
   .static_err_o(static_err_o), .event_o(event_o));

// File: rdv_chan_model.sv
// Model of the two redundant input modules with stuck-at faults.
`timescale 1ns/1ps
module rdv_chan_model
   import rdv_pkg::*;
(
   // Encoder value and fault setup.
   input wire logic [RDV_WIDTH-1:0] val_i,
   input wire logic [RDV_WIDTH-1:0] flt_a_i,
   input wire logic [RDV_WIDTH-1:0] flt_b_i,
   input wire logic [RDV_WIDTH-1:0] stuck_i,
   // Channel read-back.
   output logic [RDV_WIDTH-1:0] ch_a_o,
   output logic [RDV_WIDTH-1:0] ch_b_o
);
   // A faulted bit reads its stuck level whatever the encoder does.
   assign ch_a_o = (val_i & ~flt_a_i) | (stuck_i & flt_a_i);
   assign ch_b_o = (val_i & ~flt_b_i) | (stuck_i & flt_b_i);
endmodule

// File: test_rdv_voter.sv
// Self-checking bench for the discrepancy voter.
`timescale 1ns/1ps
module test_rdv_voter;
   import rdv_pkg::*;
   // ======
   // Signals.
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic tick = 1'b0;
   logic dpa = 1'b0;
   logic dpb = 1'b0;
   logic [15:0] disc = 16'h0004;
   logic [1:0] resp = RDV_RESP_HOLD;
   logic [7:0] val = 8'h00, fa = 8'h00, fb = 8'h00, st = 8'h00;
   logic [7:0] a, b, img, mk, pa, pb, se, ev_bit;
   logic [7:0] ev_count = 8'h00;
   logic [15:0] ev_code;
   // Response cases: response code, fault a, fault b, image after response.
   logic [31:0] cases [3] = '{32'h01050039, 32'h02000539, 32'h03050038};
   logic ev_seen = 1'b0;
   rdv_event_s ev;
   int fail_count = 0;
   int num_checks = 0;
   // Rows: value, fault a, fault b, stuck level, image, marked.
   logic [47:0] rows [4] = '{48'h3C000000_3C00, 48'h3CC300FF_3CC3,
      48'h3C000000_3C00, 48'h3C000400_3C04};
   initial forever #5 ref_clk = ~ref_clk;
   rdv_chan_model u_rdv_chan_model (.val_i(val), .flt_a_i(fa),
      .flt_b_i(fb), .stuck_i(st), .ch_a_o(a), .ch_b_o(b));
   rdv_voter u_rdv_voter (.ref_clk_i(ref_clk), .nrst_i(nrst), .tick_i(tick),
      .ch_a_i(a), .ch_b_i(b), .disc_ticks_i(disc), .resp_i(resp),
      .diag_pass_a_i(dpa), .diag_pass_b_i(dpb), .image_o(img),
      .marked_o(mk), .pass_a_o(pa), .pass_b_o(pb), .static_err_o(se),
      .event_o(ev));
   // The event is a one-cycle pulse, so it is latched here.
   always @(posedge ref_clk)
   begin
      if (ev.valid === 1'b1)
      begin
         ev_seen <= 1'b1;
         ev_bit <= ev.bit_idx;
         ev_code <= ev.code;
         ev_count <= ev_count + 8'h01;
      end
   end
   // ======
   // Tasks.
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         fail_count++;
      end
   endtask
   // One tick, then an idle edge so the voted outputs have landed.
   task tk;
      @(posedge ref_clk) #1 tick = 1'b1;
      @(posedge ref_clk) #1 tick = 1'b0;
      @(posedge ref_clk) #1;
   endtask
   task results;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ======
   // Sequence.
   initial
   begin
      repeat (2) @(posedge ref_clk);
      #1 nrst = 1'b1;
      chk("reset image", img, 8'h00);
      chk("reset marked", mk, 8'h00);
      // Four whole ticks of discrepancy time.
      disc = 16'h0004;
      for (int i = 0; i < 4; i++)
      begin
         {val, fa, fb, st} = rows[i][47:16];
         tk();
         chk("image", img, rows[i][15:8]);
         chk("marked", mk, rows[i][7:0]);
      end
      for (int n = 0; n < 10 && !ev_seen; n++)
         tk();
      chk("expiry", {7'h00, ev_seen}, 8'h01);
      chk("event bit", ev_bit, 8'h02);
      chk("code hi", ev_code[15:8], RDV_ERR_UNLOCALIZED[15:8]);
      chk("code lo", ev_code[7:0], RDV_ERR_UNLOCALIZED[7:0]);
      chk("passive", pa | pb, 8'h00);
      chk("static", se, 8'h00);
      chk("held image", img, 8'h3C);
      chk("marked", mk, 8'h04);
      fb = 8'h00;
      tk();
      chk("pass a", pa, 8'h04);
      chk("pass b", pb, 8'h00);
      chk("image", img, 8'h3C);
      dpb = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("diag pass b", pb, 8'hFF);
      dpa = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("diag pass a", pa, 8'hFF);
      // Mid-run resets; bits 0 and 2 expire together in every case.
      for (int k = 0; k < 3; k++)
      begin
         @(posedge ref_clk) #1 nrst = 1'b0;
         dpa = 1'b0;
         dpb = 1'b0;
         {fa, fb, st} = {8'h00, 8'h00, 8'h01};
         repeat (2) @(posedge ref_clk);
         #1 nrst = 1'b1;
         chk("reset pass", pa | pb, 8'h00);
         chk("reset marked", mk, 8'h00);
         chk("reset image", img, 8'h00);
         resp = cases[k][25:24];
         tk();
         chk("agreed", img, 8'h3C);
         {fa, fb} = cases[k][23:8];
         for (int n = 0; n < 6; n++)
            tk();
         chk("response", img, cases[k][7:0]);
         chk("both marked", mk, 8'h05);
         chk("lowest bit", ev_bit, 8'h00);
         chk("no passive", pa | pb, 8'h00);
      end
      // Channel A recovers, so channel B is the one passivated.
      fa = 8'h00;
      tk();
      chk("pass b", pb, 8'h05);
      chk("pass a", pa, 8'h00);
      chk("image", img, 8'h3C);
      chk("events", ev_count, 8'h04);
      results();
   end
endmodule
